// ===== src/bpc_pkg.sv
// Constants, offsets and field layout for the buck pair configuration registers
package bpc_pkg;
    // ==========================================================
    // Bus shape
    localparam int ADDR_W = 9;
    localparam int DATA_W = 32;
    localparam int IDX_W = 7;
    localparam int NCHAN = 2;
    // ==========================================================
    // Register indices (byte address is four times the index)
    localparam logic [IDX_W-1:0] IDX_CHAN_A_NORMAL_SETPOINT = 7'h3C;
    localparam logic [IDX_W-1:0] IDX_CHAN_A_STANDBY_SETPOINT = 7'h3D;
    localparam logic [IDX_W-1:0] IDX_CHAN_A_SLEEP_SETPOINT = 7'h3E;
    localparam logic [IDX_W-1:0] IDX_CHAN_A_SWITCH_MODE = 7'h3F;
    localparam logic [IDX_W-1:0] IDX_CHAN_A_CONFIG = 7'h40;
    localparam logic [IDX_W-1:0] IDX_CHAN_B_NORMAL_SETPOINT = 7'h43;
    localparam logic [IDX_W-1:0] IDX_CHAN_B_STANDBY_SETPOINT = 7'h44;
    localparam logic [IDX_W-1:0] IDX_CHAN_B_SLEEP_SETPOINT = 7'h45;
    localparam logic [IDX_W-1:0] IDX_CHAN_B_SWITCH_MODE = 7'h46;
    localparam logic [IDX_W-1:0] IDX_CHAN_B_CONFIG = 7'h47;
    // Offsets inside one channel's group
    localparam logic [IDX_W-1:0] OFF_NORMAL = 7'h00;
    localparam logic [IDX_W-1:0] OFF_STANDBY = 7'h01;
    localparam logic [IDX_W-1:0] OFF_SLEEP = 7'h02;
    localparam logic [IDX_W-1:0] OFF_MODE = 7'h03;
    localparam logic [IDX_W-1:0] OFF_CONFIG = 7'h04;
    localparam logic [IDX_W-1:0] GROUP_SIZE = 7'h05;
    // ==========================================================
    // Field positions and widths
    localparam int LEVEL_LSB = 0;
    localparam int LEVEL_W = 6;
    localparam int RANGE_BIT = 6;
    localparam int MODE_LSB = 0;
    localparam int MODE_W = 4;
    localparam int SLEEP_STATE_BIT = 5;
    localparam int ILIM_BIT = 0;
    localparam int FREQ_LSB = 2;
    localparam int PHASE_LSB = 4;
    localparam int SLEW_LSB = 6;
    localparam int SEL_W = 2;
    // ==========================================================
    // Reset values
    localparam logic [LEVEL_W-1:0] LEVEL_RST = 6'h00;
    localparam logic RANGE_RST = 1'b0;
    localparam logic [MODE_W-1:0] MODE_RST = 4'h0;
    localparam logic SLEEP_STATE_RST = 1'b0;
    localparam logic [7:0] CONFIG_RST = 8'h00;
    // ==========================================================
    // Power states and set-point mapping in millivolts
    localparam logic [1:0] PSTATE_NORMAL = 2'h0;
    localparam logic [1:0] PSTATE_STANDBY = 2'h1;
    localparam logic [1:0] PSTATE_SLEEP = 2'h2;
    localparam int MV_W = 12;
    localparam logic [MV_W-1:0] LOW_BASE_MV = 12'h190;
    localparam logic [MV_W-1:0] LOW_STEP_MV = 12'h019;
    localparam logic [MV_W-1:0] HIGH_BASE_MV = 12'h320;
    localparam logic [MV_W-1:0] HIGH_STEP_MV = 12'h032;
    localparam logic [LEVEL_W-1:0] HIGH_MAX_LEVEL = 6'h32;
endpackage

// ===== src/bpc_regs.sv
// Register bank and set-point selection for a pair of buck channels
`timescale 1ns/1ps

module bpc_regs (
    input wire logic CORE_CLK,
    input wire logic ARST_N,
    input wire logic [bpc_pkg::ADDR_W-1:0] AVS_ADDRESS,
    input wire logic AVS_READ,
    input wire logic AVS_WRITE,
    input wire logic [bpc_pkg::DATA_W-1:0] AVS_WRITEDATA,
    input wire logic [3:0] AVS_BYTEENABLE,
    output logic [bpc_pkg::DATA_W-1:0] AVS_READDATA,
    output logic AVS_WAITREQUEST,
    input wire logic CFG_LOAD,
    input wire logic [bpc_pkg::NCHAN-1:0] CFG_RANGE,
    input wire logic SINGLE_PHASE,
    input wire logic [1:0] PWR_STATE,
    output logic [bpc_pkg::NCHAN*7-1:0] CHAN_VCODE,
    output logic [bpc_pkg::NCHAN*bpc_pkg::MV_W-1:0] CHAN_VOUT_MV,
    output logic [bpc_pkg::NCHAN-1:0] CHAN_CODE_RSVD,
    output logic [bpc_pkg::NCHAN-1:0] CHAN_RUN,
    output logic [bpc_pkg::NCHAN-1:0] CHAN_PFM,
    output logic [bpc_pkg::NCHAN*bpc_pkg::MODE_W-1:0] CHAN_MODE,
    output logic [bpc_pkg::NCHAN-1:0] CHAN_ILIM_LOW,
    output logic [bpc_pkg::NCHAN*bpc_pkg::SEL_W-1:0] CHAN_FREQ,
    output logic [bpc_pkg::NCHAN*bpc_pkg::SEL_W-1:0] CHAN_PHASE,
    output logic [bpc_pkg::NCHAN*bpc_pkg::SEL_W-1:0] CHAN_SLEW
);
    import bpc_pkg::*;

    // ==========================================================
    // Bus handshake
    // Every access waits exactly one cycle so read data can come
    // from a flop without a combinational path from the address.
    logic wait_reg;
    logic wait_next;
    logic [DATA_W-1:0] rdata_reg;
    logic [DATA_W-1:0] rdata_next;

    wire req = AVS_READ | AVS_WRITE;
    wire accept = req & wait_reg;
    wire commit = req & ~wait_reg;
    wire aligned = (AVS_ADDRESS[1:0] == 2'b00);
    wire [IDX_W-1:0] idx = AVS_ADDRESS[ADDR_W-1:2];
    wire wr_fire = commit & AVS_WRITE & aligned & AVS_BYTEENABLE[0];
    wire [7:0] wbyte = AVS_WRITEDATA[7:0];

    assign wait_next = accept ? 1'b0 : 1'b1;

    // ==========================================================
    // Stored fields, one slot per channel
    logic [NCHAN-1:0][LEVEL_W-1:0] norm_reg;
    logic [NCHAN-1:0][LEVEL_W-1:0] stby_reg;
    logic [NCHAN-1:0][LEVEL_W-1:0] slp_reg;
    logic [NCHAN-1:0] range_reg;
    logic [NCHAN-1:0][MODE_W-1:0] mode_reg;
    logic [NCHAN-1:0] sleep_state_reg;
    logic [NCHAN-1:0][7:0] conf_reg;
    logic [NCHAN-1:0][7:0] rd_byte;
    logic [NCHAN-1:0] hit;

    localparam logic [IDX_W-1:0] GROUP_BASE [NCHAN] = '{
        IDX_CHAN_A_NORMAL_SETPOINT, IDX_CHAN_B_NORMAL_SETPOINT};

    genvar c;
    generate
        for (c = 0; c < NCHAN; c++) begin : g_chan
            // ==================================================
            // Address decode
            wire [IDX_W-1:0] off = idx - GROUP_BASE[c];
            wire in_grp = aligned & (idx >= GROUP_BASE[c]) & (off < GROUP_SIZE);
            wire we_norm = wr_fire & in_grp & (off == OFF_NORMAL);
            wire we_stby = wr_fire & in_grp & (off == OFF_STANDBY);
            wire we_slp = wr_fire & in_grp & (off == OFF_SLEEP);
            wire we_mode = wr_fire & in_grp & (off == OFF_MODE);
            wire we_conf = wr_fire & in_grp & (off == OFF_CONFIG);

            assign hit[c] = in_grp;

            // ==================================================
            // Read-back, unused bits forced low except config bit 1
            wire [7:0] rd_norm = {1'b0, range_reg[c], norm_reg[c]};
            wire [7:0] rd_stby = {1'b0, range_reg[c], stby_reg[c]};
            wire [7:0] rd_slp = {1'b0, range_reg[c], slp_reg[c]};
            wire [7:0] rd_mode = {2'b00, sleep_state_reg[c], 1'b0, mode_reg[c]};
            assign rd_byte[c] = ~in_grp ? 8'h00 :
                (off == OFF_NORMAL) ? rd_norm :
                (off == OFF_STANDBY) ? rd_stby :
                (off == OFF_SLEEP) ? rd_slp :
                (off == OFF_MODE) ? rd_mode : conf_reg[c];

            // ==================================================
            // Set-point levels; bit 6 of a write is dropped
            always_ff @(posedge CORE_CLK or negedge ARST_N) begin
                if (!ARST_N) begin
                    norm_reg[c] <= LEVEL_RST;
                end else if (we_norm) begin
                    norm_reg[c] <= wbyte[LEVEL_LSB +: LEVEL_W];
                end
            end

            always_ff @(posedge CORE_CLK or negedge ARST_N) begin
                if (!ARST_N) begin
                    stby_reg[c] <= LEVEL_RST;
                end else if (we_stby) begin
                    stby_reg[c] <= wbyte[LEVEL_LSB +: LEVEL_W];
                end
            end

            always_ff @(posedge CORE_CLK or negedge ARST_N) begin
                if (!ARST_N) begin
                    slp_reg[c] <= LEVEL_RST;
                end else if (we_slp) begin
                    slp_reg[c] <= wbyte[LEVEL_LSB +: LEVEL_W];
                end
            end

            // Range bit: only the configuration strobe moves it
            always_ff @(posedge CORE_CLK or negedge ARST_N) begin
                if (!ARST_N) begin
                    range_reg[c] <= RANGE_RST;
                end else if (CFG_LOAD) begin
                    range_reg[c] <= CFG_RANGE[c];
                end
            end

            // ==================================================
            // Switching mode and sleep behaviour
            always_ff @(posedge CORE_CLK or negedge ARST_N) begin
                if (!ARST_N) begin
                    mode_reg[c] <= MODE_RST;
                    sleep_state_reg[c] <= SLEEP_STATE_RST;
                end else if (we_mode) begin
                    mode_reg[c] <= wbyte[MODE_LSB +: MODE_W];
                    sleep_state_reg[c] <= wbyte[SLEEP_STATE_BIT];
                end
            end

            // Whole byte kept, bit 1 included, since it reads back as written
            always_ff @(posedge CORE_CLK or negedge ARST_N) begin
                if (!ARST_N) begin
                    conf_reg[c] <= CONFIG_RST;
                end else if (we_conf) begin
                    conf_reg[c] <= wbyte;
                end
            end

            // ==================================================
            // Effective settings driven to the power stage
            // In single-phase operation channel B follows channel A.
            wire [0:0] gov = (c == 1 && SINGLE_PHASE) ? 1'b0 : 1'(c);
            wire in_sleep = (PWR_STATE == PSTATE_SLEEP);
            wire in_stby = (PWR_STATE == PSTATE_STANDBY);
            wire [LEVEL_W-1:0] level = in_sleep ? slp_reg[gov] :
                in_stby ? stby_reg[gov] : norm_reg[gov];
            wire hi_rng = range_reg[gov];
            wire [MV_W-1:0] lvl_w = {{(MV_W-LEVEL_W){1'b0}}, level};
            wire [MV_W-1:0] mv_low = MV_W'(LOW_BASE_MV + LOW_STEP_MV * lvl_w);
            wire [MV_W-1:0] mv_high = MV_W'(HIGH_BASE_MV + HIGH_STEP_MV * lvl_w);
            wire [MV_W-1:0] mv = hi_rng ? mv_high : mv_low;
            wire rsvd = hi_rng & (level > HIGH_MAX_LEVEL);
            wire sleep_pfm = sleep_state_reg[gov];
            wire [7:0] conf = conf_reg[gov];

            always_ff @(posedge CORE_CLK or negedge ARST_N) begin
                if (!ARST_N) begin
                    CHAN_VCODE[c*7 +: 7] <= 7'h00;
                    CHAN_VOUT_MV[c*MV_W +: MV_W] <= LOW_BASE_MV;
                    CHAN_CODE_RSVD[c] <= 1'b0;
                end else begin
                    CHAN_VCODE[c*7 +: 7] <= {hi_rng, level};
                    CHAN_VOUT_MV[c*MV_W +: MV_W] <= mv;
                    CHAN_CODE_RSVD[c] <= rsvd;
                end
            end

            // Sleep with the state bit clear shuts the channel down
            always_ff @(posedge CORE_CLK or negedge ARST_N) begin
                if (!ARST_N) begin
                    CHAN_RUN[c] <= 1'b1;
                    CHAN_PFM[c] <= 1'b0;
                    CHAN_MODE[c*MODE_W +: MODE_W] <= MODE_RST;
                end else begin
                    CHAN_RUN[c] <= ~in_sleep | sleep_pfm;
                    CHAN_PFM[c] <= in_sleep & sleep_pfm;
                    CHAN_MODE[c*MODE_W +: MODE_W] <= mode_reg[gov];
                end
            end

            always_ff @(posedge CORE_CLK or negedge ARST_N) begin
                if (!ARST_N) begin
                    CHAN_ILIM_LOW[c] <= 1'b0;
                    CHAN_FREQ[c*SEL_W +: SEL_W] <= 2'h0;
                    CHAN_PHASE[c*SEL_W +: SEL_W] <= 2'h0;
                    CHAN_SLEW[c*SEL_W +: SEL_W] <= 2'h0;
                end else begin
                    CHAN_ILIM_LOW[c] <= conf[ILIM_BIT];
                    CHAN_FREQ[c*SEL_W +: SEL_W] <= conf[FREQ_LSB +: SEL_W];
                    CHAN_PHASE[c*SEL_W +: SEL_W] <= conf[PHASE_LSB +: SEL_W];
                    CHAN_SLEW[c*SEL_W +: SEL_W] <= conf[SLEW_LSB +: SEL_W];
                end
            end
        end
    endgenerate

    // ==========================================================
    // Read data: unmapped or misaligned reads answer zero
    wire [7:0] rd_any = rd_byte[0] | rd_byte[1];
    assign rdata_next = (accept & AVS_READ) ? {24'h000000, rd_any} : rdata_reg;

    always_ff @(posedge CORE_CLK or negedge ARST_N) begin
        if (!ARST_N) begin
            wait_reg <= 1'b1;
            rdata_reg <= 32'h00000000;
        end else begin
            wait_reg <= wait_next;
            rdata_reg <= rdata_next;
        end
    end

    assign AVS_WAITREQUEST = wait_reg;
    assign AVS_READDATA = rdata_reg;
endmodule // bpc_regs

// ===== tb/bpc_regs_sva.sv
// Concurrent checks on the ports of the buck pair register bank
`timescale 1ns/1ps
module bpc_regs_sva (
    input wire logic CORE_CLK,
    input wire logic ARST_N,
    input wire logic [bpc_pkg::ADDR_W-1:0] AVS_ADDRESS,
    input wire logic AVS_READ,
    input wire logic AVS_WRITE,
    input wire logic [bpc_pkg::DATA_W-1:0] AVS_WRITEDATA,
    input wire logic [3:0] AVS_BYTEENABLE,
    input wire logic [bpc_pkg::DATA_W-1:0] AVS_READDATA,
    input wire logic AVS_WAITREQUEST,
    input wire logic SINGLE_PHASE,
    input wire logic [1:0] PWR_STATE,
    input wire logic [bpc_pkg::NCHAN*7-1:0] CHAN_VCODE,
    input wire logic [bpc_pkg::NCHAN*bpc_pkg::MV_W-1:0] CHAN_VOUT_MV,
    input wire logic [bpc_pkg::NCHAN-1:0] CHAN_CODE_RSVD,
    input wire logic [bpc_pkg::NCHAN-1:0] CHAN_RUN,
    input wire logic [bpc_pkg::NCHAN-1:0] CHAN_PFM,
    input wire logic [bpc_pkg::NCHAN-1:0] CHAN_ILIM_LOW
);
    import bpc_pkg::*;
    // ==========================================================
    // Decode helpers
    wire logic [IDX_W-1:0] idx = AVS_ADDRESS[8:2];
    wire logic answer = AVS_READ && !AVS_WAITREQUEST;
    wire logic commit = AVS_WRITE && !AVS_WAITREQUEST && AVS_BYTEENABLE[0] && AVS_ADDRESS[1:0] == 2'h0;
    wire logic sp_hit = idx inside {7'h3C, 7'h3D, 7'h3E, 7'h43, 7'h44, 7'h45};
    wire logic [MV_W-1:0] lvl_a = {6'h00, CHAN_VCODE[5:0]};
    // Level only has the mapping when both range steps are modelled
    wire logic [MV_W-1:0] mv_a = CHAN_VCODE[6] ? HIGH_BASE_MV + HIGH_STEP_MV * lvl_a : LOW_BASE_MV + LOW_STEP_MV * lvl_a;
    default clocking @(posedge CORE_CLK); endclocking
    default disable iff (!ARST_N);
    // ==========================================================
    // Assertions
    a_wait_single: assert property ((AVS_READ || AVS_WRITE) && AVS_WAITREQUEST |=> !AVS_WAITREQUEST)
        else $error("waitrequest not low one cycle after request");
    a_wait_idle: assert property (!AVS_READ && !AVS_WRITE |-> AVS_WAITREQUEST)
        else $error("waitrequest low without a request");
    a_rdata_upper: assert property (answer |-> AVS_READDATA[31:8] == 24'h0)
        else $error("read data upper bits not zero");
    a_sp_bit7: assert property (answer && sp_hit |-> !AVS_READDATA[7])
        else $error("set point bit 7 reads one");
    a_mode_unused: assert property (answer && idx inside {7'h3F, 7'h46} |-> AVS_READDATA[7:6] == 2'h0 && !AVS_READDATA[4])
        else $error("mode unused bits read nonzero");
    a_unmapped_zero: assert property (answer && idx inside {7'h41, 7'h42} |-> AVS_READDATA == 32'h0)
        else $error("unmapped read nonzero");
    a_ilim_follow: assert property (commit && idx == IDX_CHAN_A_CONFIG |-> ##2 CHAN_ILIM_LOW[0] == $past(AVS_WRITEDATA[0], 2))
        else $error("current limit output does not follow write");
    a_level_follow: assert property (commit && idx == IDX_CHAN_A_NORMAL_SETPOINT && PWR_STATE == 2'h0 ##1 PWR_STATE == 2'h0
        |-> ##1 CHAN_VCODE[5:0] == $past(AVS_WRITEDATA[5:0], 2))
        else $error("normal level output does not follow write");
    a_mv_map: assert property (CHAN_VOUT_MV[11:0] == mv_a)
        else $error("millivolt output mismatches code");
    a_rsvd_flag: assert property (CHAN_CODE_RSVD[0] == (CHAN_VCODE[6] && CHAN_VCODE[5:0] > HIGH_MAX_LEVEL))
        else $error("reserved flag mismatches code");
    a_awake_run: assert property (PWR_STATE != PSTATE_SLEEP |=> CHAN_RUN[0] && !CHAN_PFM[0])
        else $error("channel not running outside sleep");
    a_pair_mirror: assert property ($past(SINGLE_PHASE) |-> CHAN_VCODE[13:7] == CHAN_VCODE[6:0] && CHAN_PFM[1] == CHAN_PFM[0])
        else $error("channel b does not mirror a in single phase");
endmodule // bpc_regs_sva

bind bpc_regs bpc_regs_sva u_bpc_regs_sva (.CORE_CLK(CORE_CLK), .ARST_N(ARST_N), .AVS_ADDRESS(AVS_ADDRESS),
    .AVS_READ(AVS_READ), .AVS_WRITE(AVS_WRITE), .AVS_WRITEDATA(AVS_WRITEDATA), .AVS_BYTEENABLE(AVS_BYTEENABLE),
    .AVS_READDATA(AVS_READDATA), .AVS_WAITREQUEST(AVS_WAITREQUEST), .SINGLE_PHASE(SINGLE_PHASE),
    .PWR_STATE(PWR_STATE), .CHAN_VCODE(CHAN_VCODE), .CHAN_VOUT_MV(CHAN_VOUT_MV), .CHAN_CODE_RSVD(CHAN_CODE_RSVD),
    .CHAN_RUN(CHAN_RUN), .CHAN_PFM(CHAN_PFM), .CHAN_ILIM_LOW(CHAN_ILIM_LOW));

// ===== tb/buck3_pair_config_regs_test.sv
// Self-checking bench for the buck pair register bank
`timescale 1ns/1ps
module buck3_pair_config_regs_test;
    import bpc_pkg::*;
    logic clk = 1'b0, rst_n = 1'b0, rd = 1'b0, wr = 1'b0, cfg_load = 1'b0, single = 1'b0, wait_req;
    logic [8:0] addr = 9'h000;
    logic [31:0] wdata = 32'h0, rdata;
    logic [3:0] be = 4'h1, freq, phase, slew;
    logic [1:0] cfg_range = 2'h0, pstate = 2'h0, rsvd, run, pfm, ilim;
    logic [13:0] vcode;
    logic [23:0] vout;
    logic [7:0] mode, q;
    int n_errors = 0, n_compared = 0;
    // ==========================================================
    // Rows: address, written byte, read back after the write
    logic [8:0] r_addr [12] = '{9'h0F0, 9'h0F4, 9'h0F8, 9'h0FC, 9'h100, 9'h10C, 9'h110, 9'h114, 9'h118, 9'h11C,
        9'h104, 9'h108};
    logic [7:0] r_wd [12] = '{8'hFF, 8'hFF, 8'hFF, 8'hFF, 8'hFF, 8'hAA, 8'h55, 8'hC1, 8'hD5, 8'h5A, 8'hFF, 8'hFF};
    logic [7:0] r_exp [12] = '{8'h3F, 8'h3F, 8'h3F, 8'h2F, 8'hFF, 8'h2A, 8'h15, 8'h01, 8'h05, 8'h5A, 8'h00, 8'h00};
    always #50 clk = ~clk;
    bpc_regs u_bpc_regs (.CORE_CLK(clk), .ARST_N(rst_n), .AVS_ADDRESS(addr), .AVS_READ(rd), .AVS_WRITE(wr),
        .AVS_WRITEDATA(wdata), .AVS_BYTEENABLE(be), .AVS_READDATA(rdata), .AVS_WAITREQUEST(wait_req),
        .CFG_LOAD(cfg_load), .CFG_RANGE(cfg_range), .SINGLE_PHASE(single), .PWR_STATE(pstate), .CHAN_VCODE(vcode),
        .CHAN_VOUT_MV(vout), .CHAN_CODE_RSVD(rsvd), .CHAN_RUN(run), .CHAN_PFM(pfm), .CHAN_MODE(mode),
        .CHAN_ILIM_LOW(ilim), .CHAN_FREQ(freq), .CHAN_PHASE(phase), .CHAN_SLEW(slew));
    // ==========================================================
    // Tasks
    task automatic chk(input logic [31:0] got, input logic [31:0] exp);
        n_compared++;
        if (got !== exp) begin
            n_errors++;
            $display("unexpected at %0t: got %h, expected %h", $time, got, exp);
        end
    endtask
    // Request held until waitrequest is sampled low; the watchdog bounds the wait
    task automatic bus(input logic w, input logic [8:0] a, input logic [7:0] d, input logic [3:0] b);
        @(posedge clk);
        addr <= a;
        rd <= !w;
        wr <= w;
        wdata <= {24'h0, d};
        be <= b;
        do @(posedge clk); while (wait_req !== 1'b0);
        q = rdata[7:0];
        rd <= 1'b0;
        wr <= 1'b0;
    endtask
    task automatic rd_chk(input logic [8:0] a, input logic [7:0] e);
        bus(1'b0, a, 8'h00, 4'h1);
        chk({24'h0, q}, {24'h0, e});
    endtask
    // Outputs lag registers by one clock; three edges leave margin
    task automatic settle;
        repeat (3) @(posedge clk);
    endtask
    task automatic close_out;
        $display("compared %0d, mismatches %0d", n_compared, n_errors);
        if (n_errors == 0 && n_compared > 0) $display("ALL CHECKS OK");
        else $display("CHECKS NOT OK");
        $finish;
    endtask
    // ==========================================================
    // Sequence
    initial begin
        repeat (8) @(posedge clk);
        rst_n <= 1'b1;
        for (int i = 0; i < 12; i++) begin
            rd_chk(r_addr[i], 8'h00);
            bus(1'b1, r_addr[i], r_wd[i], 4'h1);
            rd_chk(r_addr[i], r_exp[i]);
        end
        settle;
        chk({10'h0, ilim, freq, phase, slew, mode}, {10'h0, 2'b01, 4'hB, 4'h7, 4'h7, 8'h5F});
        $display("register rows done");
        bus(1'b1, 9'h0F0, 8'h00, 4'h0);
        rd_chk(9'h0F0, 8'h3F);
        @(posedge clk);
        cfg_load <= 1'b1;
        cfg_range <= 2'b01;
        @(posedge clk);
        cfg_load <= 1'b0;
        rd_chk(9'h0F0, 8'h7F);
        rd_chk(9'h0F8, 8'h7F);
        rd_chk(9'h110, 8'h15);
        bus(1'b1, 9'h0F0, 8'h33, 4'h1);
        rd_chk(9'h0F0, 8'h73);
        settle;
        chk({23'h0, rsvd, vcode[6:0]}, {23'h0, 2'b01, 7'h73});
        bus(1'b1, 9'h0F0, 8'h32, 4'h1);
        settle;
        chk({6'h0, vout, rsvd}, {6'h0, 12'h5AA, 12'hCE4, 2'b00});
        $display("range test done");
        @(posedge clk);
        pstate <= PSTATE_STANDBY;
        settle;
        chk({14'h0, vcode, run, pfm}, {14'h0, 7'h15, 7'h7F, 2'b11, 2'b00});
        pstate <= PSTATE_SLEEP;
        settle;
        chk({14'h0, vcode, run, pfm}, {14'h0, 7'h01, 7'h7F, 2'b01, 2'b01});
        single <= 1'b1;
        settle;
        chk({12'h0, vcode, run, pfm, ilim}, {12'h0, 7'h7F, 7'h7F, 2'b11, 2'b11, 2'b11});
        pstate <= 2'h3;
        settle;
        chk({14'h0, vcode, run, pfm}, {14'h0, 7'h72, 7'h72, 2'b11, 2'b00});
        $display("power state test done");
        @(posedge clk);
        rst_n <= 1'b0;
        settle;
        chk({wait_req, 7'h0, vout}, {1'b1, 7'h0, 12'h190, 12'h190});
        @(posedge clk);
        rst_n <= 1'b1;
        rd_chk(9'h0F0, 8'h00);
        rd_chk(9'h100, 8'h00);
        bus(1'b1, 9'h0F1, 8'h15, 4'h1);
        rd_chk(9'h0F0, 8'h00);
        $display("reset test done");
        close_out;
    end
    initial begin
        repeat (3000) @(posedge clk);
        n_errors++;
        close_out;
    end
endmodule // buck3_pair_config_regs_test
